// >>> core/ops_regs.svh
`ifndef OPS_REGS_SVH
`define OPS_REGS_SVH

// byte offsets of the output-select registers (word aligned)
`define OPS_PAIR_44_45_OFS   32'h0000_0000
`define OPS_PAIR_46_47_OFS   32'h0000_0004
`define OPS_PAIR_48_49_OFS   32'h0000_0008
`define OPS_PAIR_50_51_OFS   32'h0000_000c
`define OPS_PAIR_52_53_OFS   32'h0000_0010
`define OPS_PAIR_54_55_OFS   32'h0000_0014
`define OPS_PAIR_56_57_OFS   32'h0000_0018
`define OPS_PAIR_58_59_OFS   32'h0000_001c
`define OPS_PAIR_60_61_OFS   32'h0000_0020
`define OPS_PAIR_62_63_OFS   32'h0000_0024
`define OPS_PAIR_64_65_OFS   32'h0000_0028
`define OPS_REG_COUNT        11
`define OPS_MAP_END          32'h0000_002c

// field layout inside each register
`define OPS_EVEN_LSB         0
`define OPS_EVEN_MSB         5
`define OPS_ODD_LSB          8
`define OPS_ODD_MSB          13
`define OPS_CODE_W           6

`define OPS_FIRST_PIN        44
`define OPS_PIN_COUNT        22
`define OPS_FUNC_COUNT       64
`define OPS_CODE_RESET       6'h00
`define OPS_CODE_DEFAULT     6'h00

`endif

// >>> core/ops_pkg.sv
`default_nettype none
`include "ops_regs.svh"

package ops_pkg;
    typedef logic [`OPS_CODE_W-1:0]            ops_code_t;
    typedef ops_code_t [`OPS_PIN_COUNT-1:0]    ops_code_vec_t;
    typedef logic [`OPS_PIN_COUNT-1:0]         ops_pin_vec_t;
    typedef logic [`OPS_FUNC_COUNT-1:0]        ops_func_vec_t;
endpackage : ops_pkg

`default_nettype wire

// >>> core/ops_sel_if.sv
`default_nettype none

interface ops_sel_if;
    ops_pkg::ops_code_vec_t code;

    modport src (output code);
    modport snk (input code);
endinterface : ops_sel_if

`default_nettype wire

// >>> core/ops_pin_mux.sv
`default_nettype none
`include "ops_regs.svh"

module ops_pin_mux (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    ops_sel_if.snk                     sel,
    input  wire ops_pkg::ops_func_vec_t periph_out,
    input  wire ops_pkg::ops_pin_vec_t  port_latch,
    output var  ops_pkg::ops_pin_vec_t  pin_out,
    output var  ops_pkg::ops_pin_vec_t  pin_remapped
);

    wire ops_pkg::ops_pin_vec_t pin_d;
    wire ops_pkg::ops_pin_vec_t remap_d;

    genvar p;
    generate
        for (p = 0; p < `OPS_PIN_COUNT; p++) begin : g_pin
            logic code_used;
            assign code_used = (sel.code[p] != `OPS_CODE_DEFAULT);
            // code 0 hands the pin back to its port latch
            assign pin_d[p]   = code_used ?
                                periph_out[sel.code[p]] :
                                port_latch[p];
            assign remap_d[p] = code_used;
        end
    endgenerate

    // registered so the pad never sees a glitch while the
    // select code and the function signal change together; one
    // process owns the whole vector so no bit has two writers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out      <= '0;
            pin_remapped <= '0;
        end else begin
            pin_out      <= pin_d;
            pin_remapped <= remap_d;
        end
    end

endmodule // ops_pin_mux

`default_nettype wire

// >>> core/ops_top.sv
// Notes on behaviour
// - bits 13:8 hold the function code driving the odd pin of the pair.
// - bits 5:0 hold the function code driving the even pin of the pair.
// - bits 15:14 and 7:6 ignore writes and read back zero.
// - all selection bits are read/write and clear to zero at reset.
// - each nonzero code picks exactly one peripheral output by function number; code 0 gives the pin back to its port latch.
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`default_nettype none
`include "ops_regs.svh"

module ops_top (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output var  logic [31:0]            hrdata,
    output var  logic                   hreadyout,
    output var  logic                   hresp,
    input  wire ops_pkg::ops_func_vec_t periph_out,
    input  wire ops_pkg::ops_pin_vec_t  port_latch,
    output var  ops_pkg::ops_pin_vec_t  pin_out,
    output var  ops_pkg::ops_pin_vec_t  pin_remapped
);

    ops_sel_if sel_bus ();

    logic        addr_take;
    logic        addr_mapped;
    logic [3:0]  addr_idx;
    logic        wr_pend_q;
    logic [3:0]  wr_idx_q;
    logic [31:0] rd_d;
    logic [31:0] hrdata_q;

    ops_pkg::ops_code_vec_t code_q;

    // no wait states: every transfer completes with OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // hsize is not checked: only word transfers reach this block
    assign addr_take   = hsel && htrans[1] && hready;
    assign addr_idx    = haddr[5:2];
    assign addr_mapped = (haddr < `OPS_MAP_END) && (haddr[1:0] == 2'b00);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 4'h0;
        end else if (addr_take) begin
            // unmapped writes never arm the data phase
            wr_pend_q <= hwrite && addr_mapped;
            wr_idx_q  <= addr_idx;
        end else if (hready) begin
            wr_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int k = 0; k < `OPS_PIN_COUNT; k++) begin
                code_q[k] <= `OPS_CODE_RESET;
            end
        end else if (wr_pend_q) begin
            for (int k = 0; k < `OPS_REG_COUNT; k++) begin
                if (wr_idx_q == 4'(k)) begin
                    // bits 15:14 and 7:6 have no storage
                    code_q[2*k]   <= hwdata[`OPS_EVEN_MSB:
                                            `OPS_EVEN_LSB];
                    code_q[2*k+1] <= hwdata[`OPS_ODD_MSB:
                                            `OPS_ODD_LSB];
                end
            end
        end
    end

    // read value assembled in the address phase; a write still in its
    // data phase to the same word is forwarded so back-to-back
    // write/read returns the new value
    always_comb begin
        rd_d = 32'h0000_0000;
        for (int k = 0; k < `OPS_REG_COUNT; k++) begin
            if (addr_idx == 4'(k)) begin
                if (wr_pend_q && (wr_idx_q == 4'(k))) begin
                    rd_d[`OPS_EVEN_MSB:`OPS_EVEN_LSB] =
                        hwdata[`OPS_EVEN_MSB:`OPS_EVEN_LSB];
                    rd_d[`OPS_ODD_MSB:`OPS_ODD_LSB] =
                        hwdata[`OPS_ODD_MSB:`OPS_ODD_LSB];
                end else begin
                    rd_d[`OPS_EVEN_MSB:`OPS_EVEN_LSB] = code_q[2*k];
                    rd_d[`OPS_ODD_MSB:`OPS_ODD_LSB] = code_q[2*k+1];
                end
            end
        end
        if (!addr_mapped) begin
            rd_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata_q <= rd_d;
        end
    end

    assign sel_bus.code = code_q;

    ops_pin_mux u_mux (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .sel          (sel_bus.snk),
        .periph_out   (periph_out),
        .port_latch   (port_latch),
        .pin_out      (pin_out),
        .pin_remapped (pin_remapped)
    );

endmodule // ops_top

`default_nettype wire

// >>> core/ops_code_note_unused.sv
`default_nettype none
`default_nettype wire

// >>> tb/ops_periph_model.sv
`default_nettype none
module ops_periph_model (
    input  wire logic                   hclk,
    input  wire logic                   run,
    output var  ops_pkg::ops_func_vec_t periph_out,
    output wire ops_pkg::ops_pin_vec_t  port_latch
);
    timeunit 1ns;
    timeprecision 1ps;
    initial periph_out = 64'h0f1e_2d3c_4b5a_6978;
    // rotation makes a wrong code pick a visibly different level
    always @(posedge hclk)
        if (run) periph_out <= {periph_out[62:0], periph_out[63]};
    assign port_latch = ~periph_out[21:0];
endmodule // ops_periph_model
`default_nettype wire

// >>> tb/ops_top_properties.sv
`default_nettype none
module ops_chk (
    input wire logic                   hclk,
    input wire logic                   hresetn,
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic [31:0]            hwdata,
    input wire logic                   hready,
    input wire logic [31:0]            hrdata,
    input wire ops_pkg::ops_pin_vec_t  port_latch,
    input wire ops_pkg::ops_pin_vec_t  pin_out,
    input wire ops_pkg::ops_pin_vec_t  pin_remapped
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence wr0;
        hsel && htrans == 2'h2 && hwrite && hready && haddr == 32'h0;
    endsequence
    chk_pad_zero: assert property (
        hrdata[15:14] == 2'h0 && hrdata[7:6] == 2'h0)
        else $error("reserved bits read nonzero");
    chk_reset_clear: assert property (
        $rose(hresetn) |-> pin_remapped == '0 && hrdata == 32'h0)
        else $error("state not clear after reset");
    chk_even_code: assert property (
        wr0 ##1 hwdata[5:0] != 6'h0 |-> ##2 pin_remapped[0])
        else $error("even pin not remapped");
    chk_odd_code: assert property (
        wr0 ##1 hwdata[13:8] != 6'h0 |-> ##2 pin_remapped[1])
        else $error("odd pin not remapped");
    chk_apply_edge: assert property (
        wr0 ##1 hwdata[5:0] == 6'h0 |-> ##2 !pin_remapped[0])
        else $error("cleared code not applied");
    chk_latch_follow: assert property (
        $past(hresetn) |-> (pin_out & ~pin_remapped) ==
            ($past(port_latch) & ~pin_remapped))
        else $error("idle pin not driven by latch");
endmodule // ops_chk
bind ops_top ops_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .port_latch, .pin_out,
    .pin_remapped);
`default_nettype wire

// >>> tb/tb.sv
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
    mismatches++; $display("wrong value %s exp %h got %h", n, e, a); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, run = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0]  htrans = 0;
    logic        hreadyout, hresp;
    logic [5:0]  c;
    int          mismatches = 0, compares = 0;
    ops_pkg::ops_func_vec_t periph_out;
    ops_pkg::ops_pin_vec_t  port_latch, pin_out, pin_remapped;
    initial forever #5 hclk = ~hclk;
    ops_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .periph_out, .port_latch, .pin_out, .pin_remapped);
    ops_periph_model u_per (.hclk, .run, .periph_out, .port_latch);
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic step();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        step();
        htrans <= 2'h0;
        hwdata <= d;
        step();
        r = hrdata;
        `CHK("resp", 1'b0, hresp)
    endtask
    initial begin
        logic [31:0] r;
        repeat (16) @(posedge hclk);
        hresetn <= 1;
        // index 11 lands past the map and must read zero
        for (int k = 0; k < 12; k++) begin
            bus(0, 4 * k, 0, r);
            `CHK("reset", 32'h0, r)
            bus(1, 4 * k, 32'hffff_ffff, r);
            bus(0, 4 * k, 0, r);
            `CHK("ones", (k < 11 ? 32'h3f3f : 32'h0), r)
        end
        $display("end regs");
        run <= 0;
        for (int k = 0; k < 11; k++)
            bus(1, 4 * k, {18'h0, 6'(63 - 2 * k), 2'h0, 6'(3 * k + 1)}, r);
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 22; i++) begin
            c = i[0] ? 6'(64 - i) : 6'(3 * (i / 2) + 1);
            `CHK("route", periph_out[c], pin_out[i])
        end
        `CHK("remap", 22'h3f_ffff, pin_remapped)
        bus(1, 32'hc, 32'h0, r);
        repeat (2) @(posedge hclk);
        `CHK("latch", port_latch[7:6], pin_out[7:6])
        `CHK("unmapped", 2'h0, pin_remapped[7:6])
        $display("end route");
        run <= 1;
        bus(1, 32'h0, 32'h0000_0500, r);
        // let the cleared even code reach the pad before reset hits
        repeat (3) @(posedge hclk);
        `CHK("clear", 2'h2, pin_remapped[1:0])
        hresetn <= 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        bus(0, 32'h4, 0, r);
        `CHK("rereset", 32'h0, r)
        $display("end rereset");
        test_done();
    end
endmodule // tb
`default_nettype wire
